// >>> common/pulse_ctrl_pkg.sv
/*
 Constants shared by the pulse counter control register bank: register
 addresses, value limits, values after reset, answer codes and timing.
 Assumes a 20 MHz core clock and 16-bit register words.
*/
`default_nettype none
package pulse_ctrl_pkg;
	// ********************************************************
	// Register addresses (16-bit word registers)
	// ********************************************************
	localparam logic [15:0] ADDR_RELAY_STATE = 16'h000E;
	localparam logic [15:0] ADDR_RELAY_TASK = 16'h000F;
	localparam logic [15:0] ADDR_MAIN_SEL = 16'h0012;
	localparam logic [15:0] ADDR_CYCLE_SEL = 16'h0013;
	localparam logic [15:0] ADDR_TOTAL_SEL = 16'h0014;
	localparam logic [15:0] ADDR_MAIN_AUTO = 16'h0015;
	localparam logic [15:0] ADDR_CYCLE_AUTO = 16'h0016;
	localparam logic [15:0] ADDR_RATE = 16'h0017;
	localparam logic [15:0] ADDR_PROFILE = 16'h0018;
	localparam logic [15:0] ADDR_GAIN_HI = 16'h0019;
	localparam logic [15:0] ADDR_GAIN_LO = 16'h001A;
	localparam logic [15:0] ADDR_DIV_HI = 16'h001B;
	localparam logic [15:0] ADDR_DIV_LO = 16'h001C;
	localparam logic [15:0] ADDR_PERMIT = 16'h0023;
	// ********************************************************
	// Highest accepted value of each setting
	// ********************************************************
	localparam logic [15:0] CLEAR_SEL_MAX = 16'h0003;
	localparam logic [15:0] AUTO_MAX = 16'h0001;
	localparam logic [15:0] RATE_MAX = 16'h0009;
	localparam logic [15:0] PROFILE_MAX = 16'h0003;
	localparam logic [15:0] PERMIT_MAX = 16'h0001;
	// ********************************************************
	// Values after reset
	// ********************************************************
	localparam logic [1:0] CLEAR_SEL_RST = 2'h0;
	localparam logic AUTO_RST = 1'b0;
	localparam logic [3:0] RATE_RST = 4'h0;
	localparam logic [1:0] PROFILE_RST = 2'h0;
	localparam logic PERMIT_RST = 1'b1;
	// ********************************************************
	// Clear source codes, answer codes, timing
	// ********************************************************
	typedef enum logic [1:0] {SRC_ANY, SRC_EXT_SERIAL, SRC_BUTTON_SERIAL, SRC_SERIAL_ONLY} clear_src_t;
	localparam logic [7:0] EXC_WRITE_DENIED = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned RATE_SLOW_PERIOD_MS = 100;
	localparam int unsigned RATE_FAST_PERIOD_US = 100;
	localparam int unsigned RATE_SLOW_CYCLES = CLK_HZ / 1000 * RATE_SLOW_PERIOD_MS;
	localparam int unsigned RATE_FAST_CYCLES = CLK_HZ / 1_000_000 * RATE_FAST_PERIOD_US;
endpackage
`default_nettype wire

// >>> rtl/clear_gate.sv
/*
 Clear gate: passes clear requests for one counter according to its
 clear source code. Assumes one-cycle request pulses on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module clear_gate import pulse_ctrl_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Selection and requests
	input wire logic [1:0] select,
	input wire logic serial_req,
	input wire logic ext_req,
	input wire logic button_req,
	input wire logic auto_req,
	// Result
	output logic clear_pulse
);
	logic local_ok;

	// Local sources allowed by the code; serial always passes
	always_comb begin
		case (clear_src_t'(select))
			SRC_ANY: local_ok = ext_req | button_req;
			SRC_EXT_SERIAL: local_ok = ext_req;
			SRC_BUTTON_SERIAL: local_ok = button_req;
			SRC_SERIAL_ONLY: local_ok = 1'b0;
			default: local_ok = 1'b0;
		endcase
	end

	// Registered so the top sees a clean one-cycle pulse
	always_ff @(posedge core_clk) begin
		if (reset) begin
			clear_pulse <= 1'b0;
		end else begin
			clear_pulse <= serial_req | local_ok | auto_req; // R9
		end
	end
endmodule // clear_gate
`default_nettype wire

// >>> rtl/rate_limiter.sv
/*
 Input pulse rate limiter: an input rising edge is counted only when the
 least spacing for the selected rate code has passed since the last one.
 Assumes pulse_in is synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module rate_limiter import pulse_ctrl_pkg::*; #(
	parameter int unsigned SLOW_CYCLES = RATE_SLOW_CYCLES,
	parameter int unsigned FAST_CYCLES = RATE_FAST_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Setting and input
	input wire logic [3:0] code,
	input wire logic pulse_in,
	// Accepted pulse
	output logic count_pulse
);
	logic [31:0] acc;
	logic [31:0] limit;
	logic [31:0] step;
	logic pulse_d;
	logic ready;
	logic edge_ok;

	if (SLOW_CYCLES < 1 || FAST_CYCLES < 1) begin : g_bad_period
		$error("rate_limiter periods must be at least one cycle");
	end

	// Adding the code each cycle makes the slow period shrink as 1/code
	always_comb begin
		limit = (code == 4'h0) ? FAST_CYCLES : SLOW_CYCLES; // R12
		step = (code == 4'h0) ? 32'h0000_0001 : {28'h000_0000, code};
	end
	assign ready = (acc >= limit);
	assign edge_ok = pulse_in & ~pulse_d & ready;

	// Input edge history
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_d <= 1'b0;
		end else begin
			pulse_d <= pulse_in;
		end
	end

	// Spacing accumulator; starts saturated so the first edge counts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			acc <= 32'hFFFF_FFFF;
		end else if (edge_ok) begin
			acc <= 32'h0000_0000;
		end else if (!ready) begin
			acc <= acc + step;
		end
	end

	// Accepted pulse
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_pulse <= 1'b0;
		end else begin
			count_pulse <= edge_ok;
		end
	end
endmodule // rate_limiter
`default_nettype wire

// >>> rtl/pulse_counter_control_regs.sv
/*
 Control register bank of a pulse counter, reached through the decoded
 serial register port (one read or write request per cycle, answered on
 the next edge). Assumes the serial framing, counters and threshold
 comparison sit outside and present their results synchronously.
*/
// Functional notes
// [R1] Relay state register shows relays one to four in bits 0 to 3.
// [R2] A relay state write keeps only bits 0 to 3.
// [R3] Written relay bits drive the relay outputs directly.
// [R4] Read-only task word: bit set once that relay was activated.
// [R5] A timed relay already activated is not activated again.
// [R6] Main clear select: 0 any, 1 external, 2 button, 3 serial only.
// [R7] Cycle clear select uses the same four codes.
// [R8] Total clear select uses the same four codes.
// [R9] Serial clear always works; code 3 blocks button and external input.
// [R10] Main auto clear enable is one bit.
// [R11] Cycle auto clear enable is one bit.
// [R12] Rate code 0 allows 10 kHz, codes 1 to 9 allow 10 Hz times code.
// [R13] Profile code 0 to 3 picks the active factor set.
// [R14] Active gain factor is read-only, high and low words.
// [R15] Divider high word is read-only.
// [R16] Divider low word follows at the next address.
// [R17] Writes take effect only while write permission is 1.
// [R18] Out-of-range writes are refused and leave the setting unchanged.
`timescale 1ns/10ps
`default_nettype none
module pulse_counter_control_regs import pulse_ctrl_pkg::*; #(
	parameter int unsigned SLOW_CYCLES = RATE_SLOW_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register requests
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	// Register answers
	output logic [15:0] reg_rdata,
	output logic reg_ack,
	output logic reg_fault,
	output logic [7:0] reg_exc,
	// Relays
	input wire logic [3:0] threshold_hit,
	input wire logic [3:0] relay_timed,
	input wire logic [3:0] relay_expire,
	output logic [3:0] relay_out,
	output logic [3:0] relay_task,
	// Counter clear sources and results
	input wire logic [2:0] serial_clear,
	input wire logic external_clear_input,
	input wire logic front_button,
	input wire logic [1:0] auto_due,
	output logic clear_main,
	output logic clear_cycle,
	output logic clear_total,
	// Counting input
	input wire logic pulse_in,
	output logic count_pulse,
	// Stored factor sets
	input wire logic [3:0][31:0] profile_gain,
	input wire logic [3:0][31:0] profile_div,
	// Settings seen by the counting logic
	output logic main_auto_en,
	output logic cycle_auto_en,
	output logic [3:0] rate_code,
	output logic [1:0] active_factor_set,
	output logic serial_write_permit
);
	// ********************************************************
	// Declarations
	// ********************************************************
	logic [1:0] main_sel;
	logic [1:0] cycle_sel;
	logic [1:0] total_sel;
	logic ext_d;
	logic btn_d;
	logic ext_pulse;
	logic btn_pulse;
	logic [3:0] fire;
	logic [15:0] next_rdata;
	logic addr_known;
	logic writable;
	logic val_ok;
	logic wr_ok;
	logic wr_relay;
	logic [31:0] gain_sel;
	logic [31:0] div_sel;

	// ********************************************************
	// Request decode
	// ********************************************************
	// Active factor set picks which stored gain and divider are shown
	assign gain_sel = profile_gain[active_factor_set]; // R13
	assign div_sel = profile_div[active_factor_set];

	// Read data, write permission per address and range check
	always_comb begin
		next_rdata = 16'h0000;
		addr_known = 1'b1;
		writable = 1'b1;
		val_ok = 1'b1;
		case (reg_addr)
			ADDR_RELAY_STATE: next_rdata = {12'h000, relay_out}; // R1
			ADDR_RELAY_TASK: begin
				next_rdata = {12'h000, relay_task}; // R4
				writable = 1'b0;
			end
			ADDR_MAIN_SEL: begin
				next_rdata = {14'h0000, main_sel};
				val_ok = (reg_wdata <= CLEAR_SEL_MAX); // R18
			end
			ADDR_CYCLE_SEL: begin
				next_rdata = {14'h0000, cycle_sel};
				val_ok = (reg_wdata <= CLEAR_SEL_MAX); // R18
			end
			ADDR_TOTAL_SEL: begin
				next_rdata = {14'h0000, total_sel};
				val_ok = (reg_wdata <= CLEAR_SEL_MAX); // R18
			end
			ADDR_MAIN_AUTO: begin
				next_rdata = {15'h0000, main_auto_en};
				val_ok = (reg_wdata <= AUTO_MAX); // R18
			end
			ADDR_CYCLE_AUTO: begin
				next_rdata = {15'h0000, cycle_auto_en};
				val_ok = (reg_wdata <= AUTO_MAX); // R18
			end
			ADDR_RATE: begin
				next_rdata = {12'h000, rate_code};
				val_ok = (reg_wdata <= RATE_MAX); // R18
			end
			ADDR_PROFILE: begin
				next_rdata = {14'h0000, active_factor_set};
				val_ok = (reg_wdata <= PROFILE_MAX); // R18
			end
			ADDR_GAIN_HI: begin
				next_rdata = gain_sel[31:16]; // R14
				writable = 1'b0;
			end
			ADDR_GAIN_LO: begin
				next_rdata = gain_sel[15:0]; // R14
				writable = 1'b0;
			end
			ADDR_DIV_HI: begin
				next_rdata = div_sel[31:16]; // R15
				writable = 1'b0;
			end
			ADDR_DIV_LO: begin
				next_rdata = div_sel[15:0]; // R16
				writable = 1'b0;
			end
			ADDR_PERMIT: begin
				next_rdata = {15'h0000, serial_write_permit};
				val_ok = (reg_wdata <= PERMIT_MAX); // R18
			end
			default: addr_known = 1'b0;
		endcase
	end

	// A read in the same cycle as a write wins; the write is dropped
	assign wr_ok = reg_wr & ~reg_rd & addr_known & writable & serial_write_permit & val_ok; // R17
	assign wr_relay = wr_ok & (reg_addr == ADDR_RELAY_STATE);

	// ********************************************************
	// Answers
	// ********************************************************
	// One answer per request on the next edge; code and data hold after it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_ack <= 1'b0;
			reg_fault <= 1'b0;
			reg_exc <= 8'h00;
			reg_rdata <= 16'h0000;
		end else begin
			reg_ack <= 1'b0;
			reg_fault <= 1'b0;
			if (reg_rd) begin
				if (addr_known) begin
					reg_ack <= 1'b1;
					reg_rdata <= next_rdata;
				end else begin
					reg_fault <= 1'b1;
					reg_exc <= EXC_BAD_ADDR;
				end
			end else if (reg_wr) begin
				if (!addr_known || !writable) begin
					reg_fault <= 1'b1;
					reg_exc <= EXC_BAD_ADDR; // R15
				end else if (!serial_write_permit) begin
					reg_fault <= 1'b1;
					reg_exc <= EXC_WRITE_DENIED; // R17
				end else if (!val_ok) begin
					reg_fault <= 1'b1;
					reg_exc <= EXC_BAD_VALUE; // R18
				end else begin
					reg_ack <= 1'b1;
				end
			end
		end
	end

	// ********************************************************
	// Stored settings
	// ********************************************************
	// Clear source selections
	always_ff @(posedge core_clk) begin
		if (reset) begin
			main_sel <= CLEAR_SEL_RST;
			cycle_sel <= CLEAR_SEL_RST;
			total_sel <= CLEAR_SEL_RST;
		end else if (wr_ok) begin
			if (reg_addr == ADDR_MAIN_SEL) main_sel <= reg_wdata[1:0]; // R6
			if (reg_addr == ADDR_CYCLE_SEL) cycle_sel <= reg_wdata[1:0]; // R7
			if (reg_addr == ADDR_TOTAL_SEL) total_sel <= reg_wdata[1:0]; // R8
		end
	end

	// Auto clear enables, one bit each
	always_ff @(posedge core_clk) begin
		if (reset) begin
			main_auto_en <= AUTO_RST;
			cycle_auto_en <= AUTO_RST;
		end else if (wr_ok) begin
			if (reg_addr == ADDR_MAIN_AUTO) main_auto_en <= reg_wdata[0]; // R10
			if (reg_addr == ADDR_CYCLE_AUTO) cycle_auto_en <= reg_wdata[0]; // R11
		end
	end

	// Rate code, factor set and write permission
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rate_code <= RATE_RST;
			active_factor_set <= PROFILE_RST;
			serial_write_permit <= PERMIT_RST;
		end else if (wr_ok) begin
			if (reg_addr == ADDR_RATE) rate_code <= reg_wdata[3:0]; // R12
			if (reg_addr == ADDR_PROFILE) active_factor_set <= reg_wdata[1:0]; // R13
			// Once cleared, only a reset restores permission
			if (reg_addr == ADDR_PERMIT) serial_write_permit <= reg_wdata[0]; // R17
		end
	end

	// ********************************************************
	// Relays
	// ********************************************************
	// Timed relays may fire only while their task bit is still clear
	assign fire = threshold_hit & ~(relay_timed & relay_task); // R5

	// Relay drive; a serial write overrides the automatic behaviour
	always_ff @(posedge core_clk) begin
		if (reset) begin
			relay_out <= 4'h0;
		end else if (wr_relay) begin
			relay_out <= reg_wdata[3:0]; // R2 R3
		end else begin
			relay_out <= (relay_out | fire) & ~relay_expire;
		end
	end

	// Task bit stays set until the count falls below the threshold
	always_ff @(posedge core_clk) begin
		if (reset) begin
			relay_task <= 4'h0;
		end else begin
			relay_task <= threshold_hit & (relay_task | fire); // R4
		end
	end

	// ********************************************************
	// Counter clears and input rate
	// ********************************************************
	// Edge history of the local clear sources
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ext_d <= 1'b0;
			btn_d <= 1'b0;
		end else begin
			ext_d <= external_clear_input;
			btn_d <= front_button;
		end
	end
	assign ext_pulse = external_clear_input & ~ext_d;
	assign btn_pulse = front_button & ~btn_d;

	clear_gate u_main_gate (
		.core_clk(core_clk), .reset(reset), .select(main_sel),
		.serial_req(serial_clear[0]), .ext_req(ext_pulse), .button_req(btn_pulse),
		.auto_req(auto_due[0] & main_auto_en), .clear_pulse(clear_main)
	);
	clear_gate u_cycle_gate (
		.core_clk(core_clk), .reset(reset), .select(cycle_sel),
		.serial_req(serial_clear[1]), .ext_req(ext_pulse), .button_req(btn_pulse),
		.auto_req(auto_due[1] & cycle_auto_en), .clear_pulse(clear_cycle)
	);
	clear_gate u_total_gate (
		.core_clk(core_clk), .reset(reset), .select(total_sel),
		.serial_req(serial_clear[2]), .ext_req(ext_pulse), .button_req(btn_pulse),
		.auto_req(1'b0), .clear_pulse(clear_total)
	);
	rate_limiter #(.SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(RATE_FAST_CYCLES)) u_rate (
		.core_clk(core_clk), .reset(reset), .code(rate_code),
		.pulse_in(pulse_in), .count_pulse(count_pulse)
	);

	// ********************************************************
	// Assertions
	// ********************************************************
	property p_relay_read;
		@(posedge core_clk) disable iff (reset)
		(reg_rd && reg_addr == ADDR_RELAY_STATE) |=> (reg_ack && reg_rdata == {12'h000, $past(relay_out)});
	endproperty
	a_relay_read: assert property (p_relay_read) // R1
		else $error("relay state read mismatch");

	property p_relay_write;
		@(posedge core_clk) disable iff (reset)
		(wr_relay) |=> (relay_out == $past(reg_wdata[3:0]) && reg_ack);
	endproperty
	a_relay_write: assert property (p_relay_write) // R3
		else $error("relay write not applied");

	property p_task_follows_hit;
		@(posedge core_clk) disable iff (reset)
		(relay_task != 4'h0) |-> ((relay_task & ~$past(threshold_hit)) == 4'h0);
	endproperty
	a_task_follows_hit: assert property (p_task_follows_hit) // R4
		else $error("task bit set without threshold");

	property p_timed_no_refire;
		@(posedge core_clk) disable iff (reset)
		(relay_timed[0] && relay_task[0] && !relay_out[0] && !wr_relay) |=> !relay_out[0];
	endproperty
	a_timed_no_refire: assert property (p_timed_no_refire) // R5
		else $error("timed relay fired twice");

	property p_serial_only_blocks;
		@(posedge core_clk) disable iff (reset)
		(main_sel == 2'h3 && !serial_clear[0] && !(auto_due[0] && main_auto_en)) |=> !clear_main;
	endproperty
	a_serial_only_blocks: assert property (p_serial_only_blocks) // R9
		else $error("local source cleared main counter");

	property p_serial_clears;
		@(posedge core_clk) disable iff (reset)
		serial_clear[2] |=> clear_total;
	endproperty
	a_serial_clears: assert property (p_serial_clears) // R9
		else $error("serial clear lost");

	property p_ext_clears_cycle;
		@(posedge core_clk) disable iff (reset)
		(cycle_sel == 2'h1 && ext_pulse) ##1 (cycle_sel == 2'h1) |-> clear_cycle;
	endproperty
	a_ext_clears_cycle: assert property (p_ext_clears_cycle) // R7
		else $error("external input did not clear cycle counter");

	property p_button_blocked_ext;
		@(posedge core_clk) disable iff (reset)
		(main_sel == 2'h1 && btn_pulse && !ext_pulse && !serial_clear[0] && !auto_due[0]) |=> !clear_main;
	endproperty
	a_button_blocked_ext: assert property (p_button_blocked_ext) // R6
		else $error("button cleared with external-only select");

	property p_auto_clear;
		@(posedge core_clk) disable iff (reset)
		(auto_due[1] && cycle_auto_en) |=> clear_cycle;
	endproperty
	a_auto_clear: assert property (p_auto_clear) // R11
		else $error("auto clear of cycle counter missed");

	property p_rate_spacing;
		@(posedge core_clk) disable iff (reset)
		count_pulse |=> !count_pulse [*8];
	endproperty
	a_rate_spacing: assert property (p_rate_spacing) // R12
		else $error("count pulses too close");

	property p_range_refused;
		@(posedge core_clk) disable iff (reset)
		(reg_wr && !reg_rd && serial_write_permit && reg_addr == ADDR_RATE
			&& reg_wdata > RATE_MAX)
			|=> (reg_fault && reg_exc == EXC_BAD_VALUE && $stable(rate_code));
	endproperty
	a_range_refused: assert property (p_range_refused) // R18
		else $error("out-of-range rate code accepted");

	property p_write_denied;
		@(posedge core_clk) disable iff (reset)
		(reg_wr && !reg_rd && !serial_write_permit) |=> (reg_fault && !reg_ack && $stable(rate_code));
	endproperty
	a_write_denied: assert property (p_write_denied) // R17
		else $error("write taken without permission");

	property p_div_read;
		@(posedge core_clk) disable iff (reset)
		(reg_rd && reg_addr == ADDR_DIV_LO) |=> (reg_rdata == $past(div_sel[15:0]));
	endproperty
	a_div_read: assert property (p_div_read) // R16
		else $error("divider low word wrong");

	property p_gain_ro;
		@(posedge core_clk) disable iff (reset)
		(reg_wr && !reg_rd && reg_addr == ADDR_GAIN_HI) |=> (reg_fault && reg_exc == EXC_BAD_ADDR);
	endproperty
	a_gain_ro: assert property (p_gain_ro) // R14
		else $error("gain word accepted a write");
endmodule // pulse_counter_control_regs
`default_nettype wire

// >>> verification/host_model.sv
/*
 Serial host model: issues one register read or write at a time on the
 decoded register port and collects the answer.
 Assumes answers arrive one edge after the request is taken.
*/
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input wire logic core_clk,
	// Requests
	output logic reg_rd,
	output logic reg_wr,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	// Answers
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_fault,
	input wire logic [7:0] reg_exc
);
	// Idle port until the first request
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// One transfer; released lines show inverted values so stale data never passes
	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic [7:0] exc, output logic [1:0] st);
		st = 2'h0;
		rd = 16'h0000;
		exc = 8'h00;
		@(posedge core_clk);
		reg_rd <= ~wr;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		// Bounded wait for acknowledge or refusal
		for (int i = 0; i < 4 && st == 2'h0; i++) begin
			#1;
			st = {reg_fault, reg_ack};
			rd = reg_rdata;
			exc = reg_exc;
			if (st == 2'h0) @(posedge core_clk);
		end
	endtask
endmodule // host_model
`default_nettype wire

// >>> verification/pulse_counter_control_regs_tb_top.sv
/*
 Self-checking testbench of the pulse counter control register bank.
 Assumes the register bank answers each request and SLOW_CYCLES of 100.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_counter_control_regs_tb_top import pulse_ctrl_pkg::*;;
	logic core_clk = 1'b0, reset = 1'b1, reg_rd, reg_wr, reg_ack, reg_fault, pulse_in = 1'b0;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic [7:0] reg_exc;
	logic [3:0] threshold_hit = 4'h0, relay_timed = 4'h0, relay_expire = 4'h0, relay_out, relay_task;
	logic [2:0] serial_clear = 3'h0, s;
	logic external_clear_input = 1'b0, front_button = 1'b0, clear_main, clear_cycle, clear_total;
	logic [1:0] auto_due = 2'h0, active_factor_set;
	logic count_pulse, main_auto_en, cycle_auto_en, serial_write_permit;
	logic [3:0] rate_code;
	logic [3:0][31:0] profile_gain = {32'h0004_0004, 32'h000F_423F, 32'h0002_0002, 32'h0001_0001};
	logic [3:0][31:0] profile_div = {32'h0008_0008, 32'h0001_86A0, 32'h0006_0006, 32'h0005_0005};
	int mismatches = 0, checked = 0;
	always #25 core_clk = ~core_clk;
	pulse_counter_control_regs #(.SLOW_CYCLES(100)) i_pulse_counter_control_regs (.core_clk(core_clk),
		.reset(reset), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_fault(reg_fault), .reg_exc(reg_exc),
		.threshold_hit(threshold_hit), .relay_timed(relay_timed), .relay_expire(relay_expire),
		.relay_out(relay_out), .relay_task(relay_task), .serial_clear(serial_clear),
		.external_clear_input(external_clear_input), .front_button(front_button),
		.auto_due(auto_due), .clear_main(clear_main), .clear_cycle(clear_cycle),
		.clear_total(clear_total), .pulse_in(pulse_in), .count_pulse(count_pulse),
		.profile_gain(profile_gain), .profile_div(profile_div), .main_auto_en(main_auto_en),
		.cycle_auto_en(cycle_auto_en), .rate_code(rate_code), .active_factor_set(active_factor_set),
		.serial_write_permit(serial_write_permit));
	host_model i_host_model (.core_clk(core_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_fault(reg_fault), .reg_exc(reg_exc));
	// ********************************************************
	// Comparison and transfer helpers
	// ********************************************************
	task automatic complete_run();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Transfer with expected answer: 01 ack, 10 refusal with code
	task automatic acc(input logic wr, input logic [15:0] a, d, input logic [1:0] st_exp,
		input logic [7:0] exc_exp);
		logic [1:0] st;
		logic [7:0] exc;
		i_host_model.access(wr, a, d, rd, exc, st);
		if (st === 2'h0) begin
			mismatches++;
			$display("[FAIL] answer expected 01 seen none");
			complete_run();
		end
		chk("answer", {14'h0, st_exp}, {14'h0, st});
		if (st_exp == 2'h2) chk("refusal code", {8'h0, exc_exp}, {8'h0, exc});
	endtask
	task automatic r(input logic [15:0] a, exp);
		acc(1'b0, a, 16'h0000, 2'h1, 8'h00);
		chk("read data", exp, rd);
	endtask
	// Pulse one clear source for a cycle and collect clears over four cycles
	task automatic src(input int k);
		s = 3'h0;
		@(posedge core_clk);
		case (k)
			0: external_clear_input <= 1'b1;
			1: front_button <= 1'b1;
			2: serial_clear <= 3'h7;
			3: auto_due <= 2'h1;
			default: auto_due <= 2'h2;
		endcase
		@(posedge core_clk);
		external_clear_input <= 1'b0;
		front_button <= 1'b0;
		serial_clear <= 3'h0;
		auto_due <= 2'h0;
		repeat (4) begin
			#1 s |= {clear_total, clear_cycle, clear_main};
			@(posedge core_clk);
		end
	endtask
	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic t_relay();
		acc(1'b1, ADDR_RELAY_STATE, 16'hFFF5, 2'h1, 8'h00);
		chk("relay out", 16'h0005, {12'h0, relay_out});
		r(ADDR_RELAY_STATE, 16'h0005);
		acc(1'b1, ADDR_RELAY_STATE, 16'h0000, 2'h1, 8'h00);
		@(posedge core_clk);
		threshold_hit <= 4'h1;
		relay_timed <= 4'h1;
		repeat (3) @(posedge core_clk);
		#1 chk("task word", 16'h0011, {8'h0, relay_task, relay_out});
		r(ADDR_RELAY_TASK, 16'h0001);
		@(posedge core_clk) relay_expire <= 4'h1;
		@(posedge core_clk);
		relay_expire <= 4'h0;
		repeat (4) @(posedge core_clk);
		#1 chk("timed relay", 16'h0010, {8'h0, relay_task, relay_out});
		@(posedge core_clk) threshold_hit <= 4'h0;
		repeat (3) @(posedge core_clk);
		#1 chk("task cleared", 16'h0000, {12'h0, relay_task});
		$display("relay test done");
	endtask
	task automatic t_clear();
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, ADDR_MAIN_SEL, 16'(c), 2'h1, 8'h00);
			src(0);
			chk("external clear", {15'h0, c <= 1}, {15'h0, s[0]});
			src(1);
			chk("button clear", {15'h0, c == 0 || c == 2}, {15'h0, s[0]});
			src(2);
			chk("serial clear", 16'h0007, {13'h0, s});
		end
		acc(1'b1, ADDR_CYCLE_SEL, 16'h0001, 2'h1, 8'h00);
		acc(1'b1, ADDR_TOTAL_SEL, 16'h0002, 2'h1, 8'h00);
		src(0);
		chk("external split", 16'h0002, {13'h0, s});
		src(1);
		chk("button split", 16'h0004, {13'h0, s});
		src(3);
		chk("auto off", 16'h0000, {13'h0, s});
		acc(1'b1, ADDR_MAIN_AUTO, 16'h0001, 2'h1, 8'h00);
		src(3);
		chk("auto main", 16'h0001, {13'h0, s});
		acc(1'b1, ADDR_CYCLE_AUTO, 16'h0001, 2'h1, 8'h00);
		src(4);
		chk("auto cycle", 16'h0002, {13'h0, s});
		acc(1'b1, ADDR_CYCLE_AUTO, 16'h0002, 2'h2, EXC_BAD_VALUE);
		chk("auto enables", 16'h0003, {14'h0, main_auto_en, cycle_auto_en});
		$display("clear test done");
	endtask
	task automatic t_settings();
		s = 3'h0;
		for (int n = 0; n < 2; n++) begin
			@(posedge core_clk);
			pulse_in <= 1'b1;
			repeat (3) begin
				@(posedge core_clk);
				pulse_in <= 1'b0;
				#1 s[n] |= count_pulse;
			end
		end
		chk("counted pulses", 16'h0001, {13'h0, s});
		acc(1'b1, ADDR_RATE, 16'h000A, 2'h2, EXC_BAD_VALUE);
		chk("rate kept", 16'h0000, {12'h0, rate_code});
		acc(1'b1, ADDR_RATE, 16'h0009, 2'h1, 8'h00);
		chk("rate code", 16'h0009, {12'h0, rate_code});
		acc(1'b1, ADDR_PROFILE, 16'h0004, 2'h2, EXC_BAD_VALUE);
		acc(1'b1, ADDR_PROFILE, 16'h0002, 2'h1, 8'h00);
		chk("factor set", 16'h0002, {14'h0, active_factor_set});
		r(ADDR_GAIN_HI, 16'h000F);
		r(ADDR_GAIN_LO, 16'h423F);
		r(ADDR_DIV_HI, 16'h0001);
		r(ADDR_DIV_LO, 16'h86A0);
		acc(1'b1, ADDR_DIV_HI, 16'h0000, 2'h2, EXC_BAD_ADDR);
		acc(1'b1, ADDR_GAIN_HI, 16'h0000, 2'h2, EXC_BAD_ADDR);
		acc(1'b0, 16'h0010, 16'h0000, 2'h2, EXC_BAD_ADDR);
		acc(1'b1, ADDR_PERMIT, 16'h0000, 2'h1, 8'h00);
		acc(1'b1, ADDR_RATE, 16'h0001, 2'h2, EXC_WRITE_DENIED);
		chk("locked rate", 16'h0009, {12'h0, rate_code});
		r(ADDR_RATE, 16'h0009);
		$display("settings test done");
	endtask
	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		r(ADDR_MAIN_SEL, 16'h0000);
		chk("reset settings", 16'h0001, {7'h0, main_auto_en, cycle_auto_en, rate_code,
			active_factor_set, serial_write_permit});
		t_relay();
		t_clear();
		t_settings();
		complete_run();
	end
endmodule // pulse_counter_control_regs_tb_top
`default_nettype wire
